// ==== verilog/rsic_pkg.sv ====
`default_nettype none
package rsic_pkg;
   // Command source selection
   typedef enum logic [1:0] {
      RSIC_SRC_TERM = 2'h0,
      RSIC_SRC_KEYB = 2'h1,
      RSIC_SRC_COMM = 2'h2
   } rsic_src_t;
   // Run state machine, one-hot
   typedef enum logic [3:0] {
      RSIC_ST_STOP = 4'h1,
      RSIC_ST_RUN_RIGHT_INPUT = 4'h2,
      RSIC_ST_RUN_LEFT_INPUT = 4'h4,
      RSIC_ST_TRIP = 4'h8
   } rsic_state_t;
   // Terminal inputs after synchronisation
   typedef struct packed {
      logic run_right;
      logic run_left;
      logic enable;
      logic stop;
      logic reset;
   } rsic_term_t;
   // Commands from keyboard or serial link
   typedef struct packed {
      logic run_right;
      logic run_left;
      logic stop;
      logic reset;
   } rsic_cmd_t;
   // Register map
   localparam logic [3:0] RSIC_OFF_CTRL = 4'h0;
   localparam logic [3:0] RSIC_OFF_STAT = 4'h4;
   localparam logic [3:0] RSIC_OFF_IRQ = 4'h8;
   localparam logic [3:0] RSIC_OFF_MASK = 4'hc;
   // Control field positions
   localparam int RSIC_CTL_EDGE = 0;
   localparam int RSIC_CTL_ENA_ASG = 1;
   localparam int RSIC_CTL_STP_ASG = 2;
   localparam int RSIC_CTL_PROT_OFF = 3;
   localparam int RSIC_CTL_RUN_SRC = 4;
   localparam int RSIC_CTL_RST_SRC = 6;
   localparam logic [7:0] RSIC_CTL_RESET = 8'h06;
   // Event bit positions
   localparam int RSIC_EV_START = 0;
   localparam int RSIC_EV_STOP = 1;
   localparam int RSIC_EV_DENIED = 2;
   localparam int RSIC_EV_CLEARED = 3;
   localparam int RSIC_EV_TRIP = 4;
   localparam int RSIC_NEV = 5;
   localparam logic [4:0] RSIC_MASK_RESET = 5'h00;
endpackage
`default_nettype wire

// ==== verilog/rsic_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser with a registered previous sample for edge detection
module rsic_sync
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Asynchronous input
   input wire logic din,
   // Synchronised level and previous sample
   output logic dout,
   output logic dprev
);
   logic s1_r; // First stage, read only by second stage
   // Two stages then one history flop
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         s1_r <= 1'b0;
         dout <= 1'b0;
         dprev <= 1'b0;
      end
      else
      begin
         s1_r <= din;
         dout <= s1_r;
         dprev <= dout;
      end
   end
endmodule // rsic_sync
`default_nettype wire

// ==== verilog/rsic_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// Register slave: control, status, sticky events, mask
module rsic_regs
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Block side
   input wire logic [rsic_pkg::RSIC_NEV-1:0] events,
   input wire logic [7:0] status,
   output logic [7:0] ctrl_r,
   output logic irq
);
   logic [rsic_pkg::RSIC_NEV-1:0] irq_r; // Sticky events
   logic [rsic_pkg::RSIC_NEV-1:0] mask_r; // Interrupt mask
   logic [31:0] rd_nxt; // Read mux
   wire sel_ctrl = addr == rsic_pkg::RSIC_OFF_CTRL;
   wire sel_stat = addr == rsic_pkg::RSIC_OFF_STAT;
   wire sel_irq = addr == rsic_pkg::RSIC_OFF_IRQ;
   wire sel_mask = addr == rsic_pkg::RSIC_OFF_MASK;
   wire irq_rdclr = rd && sel_irq;
   assign rd_nxt = sel_ctrl ? {24'h0, ctrl_r} :
                   sel_stat ? {24'h0, status} :
                   sel_irq ? {27'h0, irq_r} :
                   sel_mask ? {27'h0, mask_r} : 32'h0;
   assign irq = |(irq_r & mask_r);
   // Writes; events win over read clear
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         ctrl_r <= rsic_pkg::RSIC_CTL_RESET;
         mask_r <= rsic_pkg::RSIC_MASK_RESET;
         irq_r <= '0;
         rdata <= 32'h0;
      end
      else
      begin
         if (wr && sel_ctrl)
            ctrl_r <= wdata[7:0];
         if (wr && sel_mask)
            mask_r <= wdata[rsic_pkg::RSIC_NEV-1:0];
         irq_r <= (irq_rdclr ? '0 : irq_r) | events;
         rdata <= rd ? rd_nxt : 32'h0;
      end
   end
endmodule // rsic_regs
`default_nettype wire

// ==== verilog/rsic_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Command source selectable: terminal, keyboard, serial
// - One input runs, another resets trip
// - Run accepted only while enable high
// - Enable low stops drive at once
// - Unassigned enable counts as always active
// - Stop low halts; run needs stop high
// - Trip cleared by reset rising edge
// - Level mode restarts if run held
// - Edge mode waits for fresh run edge
// - Held reset input enables automatic reset
// - No automatic reset from keyboard or serial
// - Level mode: run active while high
// - Level mode: both run inputs stop drive
// - Edge mode selected; run triggered by transition
// - Edge mode needs enable and stop continuously
// - Edge mode: latest run edge wins
// - Start refused with warning if DC loaded
module rsic_top
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Terminal digital inputs from the field
   input wire logic run_right_input,
   input wire logic run_left_input,
   input wire logic enable_input,
   input wire logic stop_input,
   input wire logic reset_input,
   // Keyboard and serial commands, same clock
   input wire rsic_pkg::rsic_cmd_t keyb_cmd,
   input wire rsic_pkg::rsic_cmd_t comm_cmd,
   // Drive side status
   input wire logic trip_in,
   input wire logic dc_loaded,
   // Register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Drive control outputs
   output logic drive_enable,
   output logic run_fwd,
   output logic run_rev,
   output logic trip_clear,
   output logic auto_reset_en,
   output logic start_denied,
   output logic irq
);
   rsic_pkg::rsic_term_t cur; // Synchronised samples
   rsic_pkg::rsic_term_t prv; // Previous samples
   rsic_pkg::rsic_state_t state_r, state_nxt; // Run state
   logic [7:0] ctrl_r; // Control register
   logic [rsic_pkg::RSIC_NEV-1:0] events; // Event pulses
   logic edge_sel_r; // Last run edge: 1 right, 0 left
   logic edge_sel_nxt;
   logic edge_pend_r; // Edge command pending
   logic edge_pend_nxt;
   logic trip_clear_nxt;
   logic start_denied_nxt;
   logic [7:0] status;

   // Synchronise every terminal input
   rsic_sync u_s_rr (.mclk(mclk), .rstn(rstn), .din(run_right_input),
      .dout(cur.run_right), .dprev(prv.run_right));
   rsic_sync u_s_rl (.mclk(mclk), .rstn(rstn), .din(run_left_input),
      .dout(cur.run_left), .dprev(prv.run_left));
   rsic_sync u_s_en (.mclk(mclk), .rstn(rstn), .din(enable_input),
      .dout(cur.enable), .dprev(prv.enable));
   rsic_sync u_s_st (.mclk(mclk), .rstn(rstn), .din(stop_input),
      .dout(cur.stop), .dprev(prv.stop));
   rsic_sync u_s_rs (.mclk(mclk), .rstn(rstn), .din(reset_input),
      .dout(cur.reset), .dprev(prv.reset));

   // Configuration fields
   wire edge_mode = ctrl_r[rsic_pkg::RSIC_CTL_EDGE];
   wire ena_asg = ctrl_r[rsic_pkg::RSIC_CTL_ENA_ASG];
   wire stp_asg = ctrl_r[rsic_pkg::RSIC_CTL_STP_ASG];
   wire prot_off = ctrl_r[rsic_pkg::RSIC_CTL_PROT_OFF];
   wire [1:0] run_src = ctrl_r[rsic_pkg::RSIC_CTL_RUN_SRC +: 2];
   wire [1:0] rst_src = ctrl_r[rsic_pkg::RSIC_CTL_RST_SRC +: 2];
   wire run_term = run_src == rsic_pkg::RSIC_SRC_TERM;
   wire rst_term = rst_src == rsic_pkg::RSIC_SRC_TERM;

   // Enable permanently active when not assigned
   wire en_ok = ena_asg ? cur.enable : 1'b1;

   // Run and stop command source selection
   wire src_rr = run_term ? cur.run_right :
                 run_src == rsic_pkg::RSIC_SRC_KEYB ? keyb_cmd.run_right : comm_cmd.run_right;
   wire src_rl = run_term ? cur.run_left :
                 run_src == rsic_pkg::RSIC_SRC_KEYB ? keyb_cmd.run_left : comm_cmd.run_left;
   // Panel sources carry no history sample
   wire src_rr_p = run_term ? prv.run_right : 1'b0;
   wire src_rl_p = run_term ? prv.run_left : 1'b0;
   wire stop_ok = run_term ? (stp_asg ? cur.stop : 1'b1) :
                  run_src == rsic_pkg::RSIC_SRC_KEYB ? !keyb_cmd.stop : !comm_cmd.stop;

   // Reset command source selection
   wire rst_now = rst_term ? cur.reset :
                  rst_src == rsic_pkg::RSIC_SRC_KEYB ? keyb_cmd.reset : comm_cmd.reset;
   wire rst_rise = rst_term ? (cur.reset && !prv.reset) : rst_now;

   // Edge detection on run inputs, either direction counts
   wire rr_edge = src_rr != src_rr_p;
   wire rl_edge = src_rl != src_rl_p;
   // Panel sources have no history, so a high level acts as the edge
   wire edge_any = run_term ? (rr_edge || rl_edge) : (src_rr || src_rl);

   // Level mode request: exactly one run input high
   wire lvl_req = (src_rr ^ src_rl);
   wire lvl_dir = src_rr;

   // Permission to run
   wire permit = en_ok && stop_ok;

   // Requested direction for this cycle
   // Edge mode uses the latched command, level mode the live inputs
   wire req = edge_mode ? edge_pend_r : lvl_req;
   wire req_dir = edge_mode ? edge_sel_r : lvl_dir;

   // Start refusal on loaded link
   // Protection can be overridden from the control register
   wire deny = dc_loaded && !prot_off;

   // Automatic reset only from terminal reset held high
   // A panel source cannot hold its reset, so it never arms automatic reset
   assign auto_reset_en = run_term && rst_term && cur.reset;

   // Edge command latch: most recent edge wins, cleared by loss of permit
   always_comb
   begin
      edge_sel_nxt = edge_sel_r;
      edge_pend_nxt = edge_pend_r;
      if (!permit || !edge_mode || state_r == rsic_pkg::RSIC_ST_TRIP)
         edge_pend_nxt = 1'b0;
      else if (edge_any)
      begin
         edge_pend_nxt = 1'b1;
         if (run_term)
            edge_sel_nxt = rl_edge ? 1'b0 : 1'b1;
         else
            edge_sel_nxt = src_rr;
         // Both inputs moving at once is ambiguous: keep the old direction
         if (run_term && rr_edge && rl_edge)
            edge_sel_nxt = edge_sel_r;
      end
   end

   // Run state machine
   always_comb
   begin
      state_nxt = state_r;
      trip_clear_nxt = 1'b0;
      start_denied_nxt = 1'b0;
      case (state_r)
         rsic_pkg::RSIC_ST_STOP:
         begin
            // A trip takes priority over any start request
            if (trip_in)
               state_nxt = rsic_pkg::RSIC_ST_TRIP;
            else if (permit && req)
            begin
               if (deny)
                  start_denied_nxt = 1'b1;
               else
                  state_nxt = req_dir ? rsic_pkg::RSIC_ST_RUN_RIGHT_INPUT : rsic_pkg::RSIC_ST_RUN_LEFT_INPUT;
            end
         end
         rsic_pkg::RSIC_ST_RUN_RIGHT_INPUT, rsic_pkg::RSIC_ST_RUN_LEFT_INPUT:
         begin
            if (trip_in)
               state_nxt = rsic_pkg::RSIC_ST_TRIP;
            // Losing permission or request stops; a new direction turns round
            else if (!permit || !req)
               state_nxt = rsic_pkg::RSIC_ST_STOP;
            else if (req_dir != (state_r == rsic_pkg::RSIC_ST_RUN_RIGHT_INPUT))
               state_nxt = req_dir ? rsic_pkg::RSIC_ST_RUN_RIGHT_INPUT : rsic_pkg::RSIC_ST_RUN_LEFT_INPUT;
         end
         rsic_pkg::RSIC_ST_TRIP:
         begin
            // Manual reset edge, or automatic reset once the fault has gone
            if (rst_rise || (auto_reset_en && !trip_in))
            begin
               trip_clear_nxt = 1'b1;
               state_nxt = rsic_pkg::RSIC_ST_STOP;
            end
         end
         default:
            state_nxt = rsic_pkg::RSIC_ST_STOP;
      endcase
   end

   // State and output registers
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         state_r <= rsic_pkg::RSIC_ST_STOP;
         edge_sel_r <= 1'b0;
         edge_pend_r <= 1'b0;
         trip_clear <= 1'b0;
         start_denied <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         edge_sel_r <= edge_sel_nxt;
         edge_pend_r <= edge_pend_nxt;
         trip_clear <= trip_clear_nxt;
         start_denied <= start_denied_nxt;
      end
   end

   // Drive outputs; enable loss gates output combinationally
   assign run_fwd = state_r == rsic_pkg::RSIC_ST_RUN_RIGHT_INPUT;
   assign run_rev = state_r == rsic_pkg::RSIC_ST_RUN_LEFT_INPUT;
   assign drive_enable = (run_fwd || run_rev) && en_ok && stop_ok;

   // Events for the sticky register
   assign events[rsic_pkg::RSIC_EV_START] = state_r == rsic_pkg::RSIC_ST_STOP &&
      (state_nxt == rsic_pkg::RSIC_ST_RUN_RIGHT_INPUT || state_nxt == rsic_pkg::RSIC_ST_RUN_LEFT_INPUT);
   assign events[rsic_pkg::RSIC_EV_STOP] = (run_fwd || run_rev) &&
      state_nxt == rsic_pkg::RSIC_ST_STOP;
   assign events[rsic_pkg::RSIC_EV_DENIED] = start_denied_nxt;
   assign events[rsic_pkg::RSIC_EV_CLEARED] = trip_clear_nxt;
   assign events[rsic_pkg::RSIC_EV_TRIP] = state_r != rsic_pkg::RSIC_ST_TRIP &&
      state_nxt == rsic_pkg::RSIC_ST_TRIP;

   // Status word: spare bits, mode, automatic reset armed, one-hot state
   assign status = {2'h0, edge_mode, auto_reset_en, state_r};

   // Register slave
   rsic_regs u_regs (
      .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .events(events), .status(status), .ctrl_r(ctrl_r), .irq(irq));

   // Enable loss drops the drive output in the same cycle
   a_enable_drop: assert property (@(posedge mclk) disable iff (!rstn)
      !en_ok |-> !drive_enable) else $error("drive enabled without enable");
   // Stop low drops the drive output
   a_stop_drop: assert property (@(posedge mclk) disable iff (!rstn)
      !stop_ok |-> !drive_enable) else $error("drive enabled with stop low");
   // No start without enable
   a_start_needs_en: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_STOP && !en_ok) |=> !run_fwd && !run_rev)
      else $error("started without enable");
   // Both level inputs high stops
   a_both_stop: assert property (@(posedge mclk) disable iff (!rstn)
      (!edge_mode && src_rr && src_rl && !trip_in) |=> !run_fwd && !run_rev)
      else $error("running with both run inputs");
   // Denied start stays stopped and warns
   a_deny_start: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_STOP && deny && permit && req && !trip_in)
      |=> start_denied && !run_fwd && !run_rev) else $error("start not denied");
   // Reset rising edge clears trip
   a_reset_clear: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_TRIP && rst_rise) |=> trip_clear)
      else $error("trip not cleared");
   // No auto reset from non terminal sources
   a_auto_src: assert property (@(posedge mclk) disable iff (!rstn)
      !run_term |-> !auto_reset_en) else $error("auto reset from panel source");
   // Edge mode stays stopped after trip clear without new edge
   a_edge_wait: assert property (@(posedge mclk) disable iff (!rstn)
      (edge_mode && trip_clear && !edge_any) |=> !run_fwd && !run_rev)
      else $error("edge mode restarted without edge");
   // Level mode restarts after clear if run held
   a_level_restart: assert property (@(posedge mclk) disable iff (!rstn)
      (!edge_mode && trip_clear && lvl_req && permit && !deny && !trip_in
       && $stable(ctrl_r)) |=> run_fwd || run_rev) else $error("level no restart");

   // Checks on source selection, trip handling and the edge latch
   // Keyboard source starts the drive in level mode
   a_keyb_run: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_STOP && run_src == rsic_pkg::RSIC_SRC_KEYB && !edge_mode
       && keyb_cmd.run_right && !keyb_cmd.run_left && permit && !deny && !trip_in)
      |=> run_fwd) else $error("keyboard run ignored");

   // Unassigned enable never gates the drive output
   a_free_enable: assert property (@(posedge mclk) disable iff (!rstn)
      (!ena_asg && stop_ok && run_fwd) |-> drive_enable) else $error("enable not free");

   // A fault always leads into the trip state
   a_trip_entry: assert property (@(posedge mclk) disable iff (!rstn)
      (trip_in && state_r != rsic_pkg::RSIC_ST_TRIP) |=> state_r == rsic_pkg::RSIC_ST_TRIP)
      else $error("trip not entered");

   // Trip holds until a reset edge or automatic reset
   a_trip_hold: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_TRIP && !rst_rise && !auto_reset_en)
      |=> state_r == rsic_pkg::RSIC_ST_TRIP) else $error("trip left without reset");

   // Held terminal reset clears the trip once the fault is gone
   a_auto_clear: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_TRIP && auto_reset_en && !trip_in)
      |=> trip_clear && state_r == rsic_pkg::RSIC_ST_STOP) else $error("no automatic reset");

   // Right run input alone high starts the right direction
   a_level_run: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_STOP && !edge_mode && lvl_req && lvl_dir && permit
       && !deny && !trip_in) |=> run_fwd) else $error("level run ignored");

   // Level mode with no run input high never runs
   a_level_idle: assert property (@(posedge mclk) disable iff (!rstn)
      (!edge_mode && !src_rr && !src_rl) |=> !run_fwd && !run_rev)
      else $error("running without run input");

   // Pending edge command starts the drive
   a_edge_start: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_STOP && edge_mode && edge_pend_r && permit && !deny
       && !trip_in) |=> run_fwd || run_rev) else $error("edge start ignored");

   // A lone right edge selects the right direction
   a_edge_latest: assert property (@(posedge mclk) disable iff (!rstn)
      (edge_mode && run_term && permit && state_r != rsic_pkg::RSIC_ST_TRIP && rr_edge
       && !rl_edge) |=> edge_sel_r && edge_pend_r) else $error("right edge not latched");

   // Newer left edge turns a right run around
   a_dir_swap: assert property (@(posedge mclk) disable iff (!rstn)
      (state_r == rsic_pkg::RSIC_ST_RUN_RIGHT_INPUT && edge_mode && edge_pend_r && !edge_sel_r
       && permit && !trip_in) |=> run_rev) else $error("direction not swapped");

   // Loss of permission drops the edge command and the run
   a_edge_drop: assert property (@(posedge mclk) disable iff (!rstn)
      (edge_mode && !permit) |=> !edge_pend_r && !run_fwd && !run_rev)
      else $error("edge command kept");

   // Panel reset source never arms automatic reset
   a_reset_src: assert property (@(posedge mclk) disable iff (!rstn)
      !rst_term |-> !auto_reset_en) else $error("auto reset from panel reset");

   // Synchronised level lags its pin by two edges
   a_sync_delay: assert property (@(posedge mclk) disable iff (!rstn)
      ($past(rstn) && $past(rstn, 2)) |-> cur.enable == $past(enable_input, 2))
      else $error("sync latency wrong");

   // Previous sample is the synchronised level one edge back
   a_edge_history: assert property (@(posedge mclk) disable iff (!rstn)
      $past(rstn) |-> prv.stop == $past(cur.stop)) else $error("history sample wrong");
endmodule // rsic_top
`default_nettype wire

// ==== verif/rsic_plc.sv ====
`timescale 1ns/10ps
`default_nettype none
// Field controller model: drives the terminal contacts like a plc
module rsic_plc
(
   // Clock
   input wire logic mclk,
   // Wanted levels: run right, run left, enable, stop, reset
   input wire logic [4:0] want,
   // Terminal digital inputs of the block
   output logic run_right_input,
   output logic run_left_input,
   output logic enable_input,
   output logic stop_input,
   output logic reset_input
);
   // Idle contacts at time zero: enable and stop closed
   initial
   begin
      {run_right_input, run_left_input, enable_input, stop_input, reset_input} = 5'h06;
   end
   // Change only after an edge, then hold steady as a real contact does
   always @(posedge mclk)
   begin
      {run_right_input, run_left_input, enable_input, stop_input, reset_input} <= want;
   end
endmodule // rsic_plc
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the run and stop input control
module testbench;
   logic mclk = 1'b0; // System clock
   logic rstn = 1'b0; // Reset, active low
   logic [4:0] want = 5'h06; // Wanted field levels
   rsic_pkg::rsic_cmd_t keyb_cmd = '0; // Keyboard command
   rsic_pkg::rsic_cmd_t comm_cmd = '0; // Serial command
   logic trip_in = 1'b0; // Drive fault
   logic dc_loaded = 1'b0; // Loaded link
   logic [3:0] addr = 4'h0; // Register address
   logic [31:0] wdata = 32'h0; // Write data
   logic wr = 1'b0; // Write strobe
   logic rd = 1'b0; // Read strobe
   logic [31:0] rdata; // Read data
   logic [31:0] d; // Last word read
   logic rr, rl, en, st, rs; // Terminal pins
   logic drive_enable, run_fwd, run_rev, trip_clear, auto_reset_en, start_denied, irq;
   logic saw_clr = 1'b0; // Trip clear pulse seen
   logic saw_den = 1'b0; // Denial pulse seen
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   // Far side contacts
   rsic_plc u_rsic_plc (.mclk(mclk), .want(want), .run_right_input(rr),
      .run_left_input(rl), .enable_input(en), .stop_input(st), .reset_input(rs));
   // Block under test
   rsic_top u_rsic_top (.mclk(mclk), .rstn(rstn), .run_right_input(rr),
      .run_left_input(rl), .enable_input(en), .stop_input(st), .reset_input(rs),
      .keyb_cmd(keyb_cmd), .comm_cmd(comm_cmd), .trip_in(trip_in), .dc_loaded(dc_loaded),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .drive_enable(drive_enable), .run_fwd(run_fwd), .run_rev(run_rev),
      .trip_clear(trip_clear), .auto_reset_en(auto_reset_en),
      .start_denied(start_denied), .irq(irq));
   // Clock generator
   initial
   begin
      forever #50 mclk = ~mclk;
   end
   // Catch one-cycle pulses and cut a hang short
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (trip_clear === 1'b1) saw_clr <= 1'b1;
      if (start_denied === 1'b1) saw_den <= 1'b1;
      if (cyc == 5000)
      begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end
   // Compare one result
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked = checked + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Wait n edges, then let them settle
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Set field levels and wait out the synchroniser
   task automatic pin(input logic [4:0] v);
      @(posedge mclk);
      want <= v;
      wt(6);
   endtask
   // One-cycle register write
   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      wt(1);
   endtask
   // One-cycle register read, data taken in the following cycle
   task automatic rreg(input logic [3:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Trip pulse on the drive side
   task automatic trip();
      @(posedge mclk);
      trip_in <= 1'b1;
      saw_clr <= 1'b0;
      wt(3);
      chk("trip stop", 32'h0, {31'h0, run_fwd});
      @(posedge mclk);
      trip_in <= 1'b0;
      wt(3);
   endtask
   // Values straight after reset
   task automatic t_reset();
      chk("run_fwd", 32'h0, {31'h0, run_fwd});
      rreg(rsic_pkg::RSIC_OFF_CTRL);
      chk("ctrl", 32'h06, d);
      rreg(rsic_pkg::RSIC_OFF_MASK);
      chk("mask", 32'h0, d);
      rreg(rsic_pkg::RSIC_OFF_STAT);
      chk("status", 32'h01, d);
      rreg(4'h2);
      chk("unmapped", 32'h0, d);
      $display("test reset done");
   endtask
   // Level mode runs, conflicts and interlocks
   task automatic t_level();
      pin(5'h12);
      chk("no enable", 32'h0, {31'h0, run_fwd});
      pin(5'h16);
      chk("run right", 32'h1, {31'h0, run_fwd});
      chk("drive on", 32'h1, {31'h0, drive_enable});
      pin(5'h1e);
      chk("both fwd", 32'h0, {31'h0, run_fwd});
      chk("both rev", 32'h0, {31'h0, run_rev});
      pin(5'h0e);
      chk("run left", 32'h1, {31'h0, run_rev});
      pin(5'h0a);
      chk("enable off", 32'h0, {31'h0, drive_enable});
      chk("enable stop", 32'h0, {31'h0, run_rev});
      pin(5'h0c);
      chk("stop low", 32'h0, {31'h0, run_rev});
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'h04);
      pin(5'h12);
      chk("no enable pin", 32'h1, {31'h0, run_fwd});
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'h06);
      pin(5'h06);
      $display("test level done");
   endtask
   // Trip and manual reset in level mode
   task automatic t_trip();
      pin(5'h16);
      trip();
      rreg(rsic_pkg::RSIC_OFF_STAT);
      chk("tripped", 32'h08, d);
      pin(5'h17);
      chk("clear", 32'h1, {31'h0, saw_clr});
      chk("restart", 32'h1, {31'h0, run_fwd});
      pin(5'h06);
      $display("test trip done");
   endtask
   // Edge mode: last edge wins, stop drops the command
   task automatic t_edge();
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'h07);
      pin(5'h16);
      chk("edge right", 32'h1, {31'h0, run_fwd});
      pin(5'h06);
      chk("edge fall", 32'h1, {31'h0, run_fwd});
      pin(5'h0e);
      chk("edge left", 32'h1, {31'h0, run_rev});
      pin(5'h0c);
      chk("edge stop", 32'h0, {31'h0, run_rev});
      pin(5'h0e);
      chk("no new edge", 32'h0, {31'h0, run_rev});
      pin(5'h1e);
      chk("latest edge", 32'h1, {31'h0, run_fwd});
      trip();
      pin(5'h1f);
      chk("edge clear", 32'h1, {31'h0, saw_clr});
      chk("edge wait", 32'h0, {31'h0, run_fwd});
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'h06);
      pin(5'h06);
      $display("test edge done");
   endtask
   // Automatic reset and keyboard source
   task automatic t_auto();
      pin(5'h07);
      chk("auto on", 32'h1, {31'h0, auto_reset_en});
      trip();
      chk("auto clear", 32'h1, {31'h0, saw_clr});
      rreg(rsic_pkg::RSIC_OFF_STAT);
      chk("auto state", 32'h11, d);
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'h56);
      chk("auto keyb", 32'h0, {31'h0, auto_reset_en});
      @(posedge mclk);
      keyb_cmd <= 4'h8;
      wt(4);
      chk("keyb run", 32'h1, {31'h0, run_fwd});
      @(posedge mclk);
      keyb_cmd <= 4'h0;
      wt(4);
      chk("keyb off", 32'h0, {31'h0, run_fwd});
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'ha6);
      @(posedge mclk);
      comm_cmd <= 4'h4;
      wt(4);
      chk("comm run", 32'h1, {31'h0, run_rev});
      trip();
      chk("comm no auto", 32'h0, {31'h0, saw_clr});
      @(posedge mclk);
      comm_cmd <= 4'h1;
      wt(4);
      chk("comm reset", 32'h1, {31'h0, saw_clr});
      @(posedge mclk);
      comm_cmd <= 4'h0;
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'h06);
      pin(5'h06);
      $display("test auto done");
   endtask
   // Start refused on a loaded link, interrupt raised, masked, cleared
   task automatic t_irq();
      rreg(rsic_pkg::RSIC_OFF_IRQ);
      wreg(rsic_pkg::RSIC_OFF_MASK, 32'h04);
      @(posedge mclk);
      dc_loaded <= 1'b1;
      saw_den <= 1'b0;
      pin(5'h16);
      chk("denied run", 32'h0, {31'h0, run_fwd});
      chk("denied", 32'h1, {31'h0, saw_den});
      chk("irq", 32'h1, {31'h0, irq});
      wreg(rsic_pkg::RSIC_OFF_MASK, 32'h00);
      wt(1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wreg(rsic_pkg::RSIC_OFF_MASK, 32'h04);
      pin(5'h06);
      rreg(rsic_pkg::RSIC_OFF_IRQ);
      chk("sticky", 32'h1, {31'h0, d[rsic_pkg::RSIC_EV_DENIED]});
      rreg(rsic_pkg::RSIC_OFF_IRQ);
      chk("read clear", 32'h0, d);
      wt(1);
      chk("irq clear", 32'h0, {31'h0, irq});
      wreg(rsic_pkg::RSIC_OFF_CTRL, 32'h0e);
      pin(5'h16);
      chk("prot off", 32'h1, {31'h0, run_fwd});
      pin(5'h06);
      $display("test irq done");
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("Counts: %0d checked, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      wt(1);
      t_reset();
      t_level();
      t_trip();
      t_edge();
      t_auto();
      t_irq();
      conclude();
   end
endmodule // testbench
`default_nettype wire
